// [logic/counter_event_defines.vh]
// Constants for the counter event and output logic: register offsets, fields, resets and codes.
// Assumes inclusion by bare name from files under logic/.
`ifndef COUNTER_EVENT_DEFINES_VH
`define COUNTER_EVENT_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_COUNTER_CONTROL 6'h00
`define OFS_IRQ_REQUEST 6'h04
`define OFS_IRQ_FORCE 6'h08
`define OFS_IRQ_ENABLE_MASK 6'h0C
`define OFS_IRQ_MASKED_VIEW 6'h10
`define OFS_OUTPUT_ACTION 6'h14
`define OFS_COUNT_VALUE 6'h18
`define OFS_TOP_VALUE 6'h1C
`define OFS_COMPARE 6'h20
`define OFS_COMPARE_SHADOW 6'h24
`define OFS_CAPTURE 6'h28
`define OFS_RUN_CONTROL 6'h2C

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define CTRL_MATCH_ON_ENTRY 0
`define CTRL_DIR_LSB 16
`define CTRL_DIR_MSB 17
`define CTRL_MODE_LSB 24
`define CTRL_MODE_MSB 26
`define ACT_COMPARE_LSB 0
`define ACT_WRAP_HIGH_LSB 2
`define ACT_WRAP_LOW_LSB 4
`define IRQ_TERMINAL_BIT 0
`define IRQ_COMPARE_BIT 1
`define RUN_ENABLE_BIT 0
`define RUN_RELOAD_BIT 1
`define RUN_CAPTURE_BIT 2

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define RESET_COUNTER_CONTROL 32'h00000000
`define RESET_OUTPUT_ACTION 6'h3F
`define RESET_IRQ_MASK 2'h0
`define ACTION_SET 2'h0
`define ACTION_CLEAR 2'h1
`define ACTION_TOGGLE 2'h2
`define ACTION_HOLD 2'h3
`define DIR_UP 2'h0
`define DIR_DOWN 2'h1
`define DIR_UPDOWN_1 2'h2
`define DIR_UPDOWN_2 2'h3
`define MODE_TIMER 3'h0
`define MODE_CAPTURE 3'h2
`define MODE_QUADRATURE 3'h3
`define MODE_PWM 3'h4
`define MODE_DEADTIME 3'h5
`define MODE_RANDOM 3'h6
`define TRIGGER_PULSE_TICKS 2'h2

`endif

// [logic/trigger_pulse_stretch.v]
// One trigger output stretched to a fixed number of system pulse ticks.
// Assumes a one-cycle event strobe and a one-cycle tick enable on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "counter_event_defines.vh"
module trigger_pulse_stretch (
   input wire clock,
   input wire reset_n,
   input wire event_strobe,
   input wire sys_tick,
   output reg pulse
);
   reg [1:0] ticks_left;

   // A new event restarts the window so pulses never run short.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ticks_left <= 2'h0;
         pulse <= 1'b0;
      end else if (event_strobe) begin
         ticks_left <= `TRIGGER_PULSE_TICKS;
         pulse <= 1'b1;
      end else if (sys_tick && ticks_left != 2'h0) begin
         ticks_left <= ticks_left - 2'h1;
         pulse <= (ticks_left != 2'h1);
      end
   end
endmodule
`default_nettype wire

// [logic/counter_event_output_logic.v]
// One counter channel: counting, wrap and compare events, trigger pulses, interrupt and wave output.
// Assumes an APB master on the same clock; count and capture inputs arrive from pins.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "counter_event_defines.vh"
module counter_event_output_logic #(
   parameter WIDTH = 16,
   parameter TICK_DIV = 1,
   parameter SYS_DIV = 1
) (
   input wire clock,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire count_in,
   input wire capture_in,
   output wire counter_wrap_high_event,
   output wire counter_wrap_low_event,
   output wire compare_capture_event,
   output wire counter_irq,
   output reg wave_out,
   output wire wave_out_n,
   output reg mode_timer,
   output reg mode_capture,
   output reg mode_quadrature,
   output reg mode_pwm,
   output reg deadtime_wave_mode,
   output reg random_wave_mode
);
   // ------------------------------------------------------------
   // Reset release and rate dividers
   // ------------------------------------------------------------
   reg [1:0] reset_sync;
   wire reset_n = reset_sync[1];

   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         reset_sync <= 2'h0;
      else
         reset_sync <= {reset_sync[0], 1'b1};
   end

   reg [7:0] tick_count;
   reg [7:0] sys_count;
   wire timebase_tick = (tick_count == TICK_DIV[7:0] - 8'h01);
   wire sys_tick = (sys_count == SYS_DIV[7:0] - 8'h01);

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_count <= 8'h00;
         sys_count <= 8'h00;
      end else begin
         tick_count <= timebase_tick ? 8'h00 : tick_count + 8'h01;
         sys_count <= sys_tick ? 8'h00 : sys_count + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // A level is accepted only once the second and third stages agree.
   reg [2:0] count_sync;
   reg [2:0] capture_sync;
   reg count_level;
   reg capture_level;
   reg capture_prev;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_sync <= 3'h0;
         capture_sync <= 3'h0;
         count_level <= 1'b0;
         capture_level <= 1'b0;
         capture_prev <= 1'b0;
      end else begin
         count_sync <= {count_sync[1:0], count_in};
         capture_sync <= {capture_sync[1:0], capture_in};
         if (count_sync[1] == count_sync[2])
            count_level <= count_sync[2];
         if (capture_sync[1] == capture_sync[2])
            capture_level <= capture_sync[2];
         capture_prev <= capture_level;
      end
   end

   wire capture_edge = capture_level && !capture_prev;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [31:0] counter_control;
   reg [5:0] output_action_control;
   reg [1:0] irq_request;
   reg [1:0] irq_enable_mask;
   reg [WIDTH-1:0] count_value;
   reg [WIDTH-1:0] top_value;
   reg [WIDTH-1:0] compare;
   reg [WIDTH-1:0] compare_shadow;
   reg [WIDTH-1:0] capture_value;
   reg running;
   reg count_down;
   reg capture_pending;

   wire [1:0] direction = counter_control[`CTRL_DIR_MSB:`CTRL_DIR_LSB];
   wire [2:0] mode = counter_control[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
   wire match_on_entry = counter_control[`CTRL_MATCH_ON_ENTRY];
   wire [1:0] irq_masked_view = irq_request & irq_enable_mask;

   wire setup = psel && !penable;
   wire write_now = psel && penable && pwrite;
   wire [5:0] offset = paddr[5:0];
   wire sw_reload = write_now && offset == `OFS_RUN_CONTROL && pwdata[`RUN_RELOAD_BIT];
   wire sw_capture = write_now && offset == `OFS_RUN_CONTROL && pwdata[`RUN_CAPTURE_BIT];

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   // Quadrature, dead-time and random modes count like the timer here.
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mode_timer <= 1'b0;
         mode_capture <= 1'b0;
         mode_quadrature <= 1'b0;
         mode_pwm <= 1'b0;
         deadtime_wave_mode <= 1'b0;
         random_wave_mode <= 1'b0;
      end else begin
         mode_timer <= (mode == `MODE_TIMER);
         mode_capture <= (mode == `MODE_CAPTURE);
         mode_quadrature <= (mode == `MODE_QUADRATURE);
         mode_pwm <= (mode == `MODE_PWM);
         deadtime_wave_mode <= (mode == `MODE_DEADTIME);
         random_wave_mode <= (mode == `MODE_RANDOM);
      end
   end

   // ------------------------------------------------------------
   // Next count and events
   // ------------------------------------------------------------
   reg [WIDTH-1:0] next_count;
   reg next_down;
   reg wrap_high;
   reg wrap_low;
   reg terminal_count_condition;
   wire step = running && timebase_tick && count_level;

   always @* begin
      next_count = count_value;
      next_down = count_down;
      wrap_high = 1'b0;
      wrap_low = 1'b0;
      if (step) begin
         case (direction)
            `DIR_UP: begin
               next_down = 1'b0;
               if (count_value == top_value) begin
                  next_count = {WIDTH{1'b0}};
                  wrap_high = 1'b1;
               end else
                  next_count = count_value + 1'b1;
            end
            `DIR_DOWN: begin
               next_down = 1'b1;
               if (count_value == {WIDTH{1'b0}}) begin
                  next_count = top_value;
                  wrap_low = 1'b1;
               end else
                  next_count = count_value - 1'b1;
            end
            default: begin
               if (!count_down && count_value == top_value) begin
                  next_down = 1'b1;
                  next_count = count_value - 1'b1;
                  wrap_high = 1'b1;
               end else if (count_down && count_value == {WIDTH{1'b0}}) begin
                  next_down = 1'b0;
                  next_count = count_value + 1'b1;
                  wrap_low = 1'b1;
               end else if (count_down)
                  next_count = count_value - 1'b1;
               else
                  next_count = count_value + 1'b1;
            end
         endcase
      end
   end

   // Up-down mode 1 drops wrap-high entirely; mode 2 keeps both ends.
   wire wrap_high_event = wrap_high && direction != `DIR_UPDOWN_1;
   wire wrap_low_event = wrap_low;

   always @* begin
      terminal_count_condition = wrap_high_event || wrap_low_event;
   end

   wire capture_mode = (mode == `MODE_CAPTURE);
   wire capture_now = capture_mode && (capture_edge || sw_capture || capture_pending);
   wire count_changes = step && next_count != count_value;
   wire entry_hit = next_count == compare && count_value != compare;
   wire exit_hit = count_value == compare && next_count != compare;
   wire compare_hit_flag = !capture_mode && count_changes && (match_on_entry ? entry_hit : exit_hit);
   wire capture_hit = capture_now && running && timebase_tick;
   wire compare_event = compare_hit_flag || capture_hit;

   // ------------------------------------------------------------
   // Counter state
   // ------------------------------------------------------------
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_value <= {WIDTH{1'b0}};
         count_down <= 1'b0;
         capture_pending <= 1'b0;
         capture_value <= {WIDTH{1'b0}};
      end else begin
         if (sw_reload) begin
            count_value <= (direction == `DIR_DOWN) ? top_value : {WIDTH{1'b0}};
            count_down <= (direction == `DIR_DOWN);
         end else if (write_now && offset == `OFS_COUNT_VALUE)
            count_value <= pwdata[WIDTH-1:0];
         else begin
            count_value <= next_count;
            count_down <= next_down;
         end
         // Captures wait for the next timebase tick so they line up with counting.
         if (capture_hit) begin
            capture_pending <= 1'b0;
            capture_value <= count_value;
         end else if (capture_mode && (capture_edge || sw_capture))
            capture_pending <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Register writes and interrupt requests
   // ------------------------------------------------------------
   wire [1:0] hw_set = {compare_event, terminal_count_condition};
   wire [1:0] force_set = (write_now && offset == `OFS_IRQ_FORCE) ? pwdata[1:0] : 2'h0;
   wire [1:0] clear_bits = (write_now && offset == `OFS_IRQ_REQUEST) ? pwdata[1:0] : 2'h0;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         counter_control <= `RESET_COUNTER_CONTROL;
         output_action_control <= `RESET_OUTPUT_ACTION;
         irq_request <= 2'h0;
         irq_enable_mask <= `RESET_IRQ_MASK;
         top_value <= {WIDTH{1'b0}};
         compare <= {WIDTH{1'b0}};
         compare_shadow <= {WIDTH{1'b0}};
         running <= 1'b0;
      end else begin
         // Hardware and force sets win over a clear in the same cycle.
         irq_request <= (irq_request & ~clear_bits) | hw_set | force_set;
         if (capture_hit) begin
            compare_shadow <= compare;
            compare <= count_value;
         end else if (write_now && offset == `OFS_COMPARE)
            compare <= pwdata[WIDTH-1:0];
         if (!capture_hit && write_now && offset == `OFS_COMPARE_SHADOW)
            compare_shadow <= pwdata[WIDTH-1:0];
         if (write_now) begin
            case (offset)
               `OFS_COUNTER_CONTROL: counter_control <= pwdata;
               `OFS_OUTPUT_ACTION: output_action_control <= pwdata[5:0];
               `OFS_IRQ_ENABLE_MASK: irq_enable_mask <= pwdata[1:0];
               `OFS_TOP_VALUE: top_value <= pwdata[WIDTH-1:0];
               `OFS_RUN_CONTROL: running <= pwdata[`RUN_ENABLE_BIT] | pwdata[`RUN_RELOAD_BIT];
               default: running <= running;
            endcase
         end
      end
   end

   assign counter_irq = |irq_masked_view;

   // ------------------------------------------------------------
   // Wave output
   // ------------------------------------------------------------
   function apply_action;
      input [1:0] action;
      input level;
      begin
         case (action)
            `ACTION_SET: apply_action = 1'b1;
            `ACTION_CLEAR: apply_action = 1'b0;
            `ACTION_TOGGLE: apply_action = !level;
            default: apply_action = level;
         endcase
      end
   endfunction

   reg next_wave;

   // Wrap-low, then wrap-high, then compare: compare is applied last and so dominates.
   always @* begin
      next_wave = wave_out;
      if (wrap_low_event)
         next_wave = apply_action(output_action_control[`ACT_WRAP_LOW_LSB+1:`ACT_WRAP_LOW_LSB], next_wave);
      if (wrap_high_event)
         next_wave = apply_action(output_action_control[`ACT_WRAP_HIGH_LSB+1:`ACT_WRAP_HIGH_LSB], next_wave);
      if (compare_event)
         next_wave = apply_action(output_action_control[`ACT_COMPARE_LSB+1:`ACT_COMPARE_LSB], next_wave);
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         wave_out <= 1'b0;
      else
         wave_out <= next_wave;
   end

   assign wave_out_n = !wave_out;

   // ------------------------------------------------------------
   // Trigger pulses
   // ------------------------------------------------------------
   wire [2:0] event_strobes = {compare_event, wrap_low_event, wrap_high_event};
   wire [2:0] event_pulses;

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : pulses
         trigger_pulse_stretch stretch (
            .clock(clock),
            .reset_n(reset_n),
            .event_strobe(event_strobes[i]),
            .sys_tick(sys_tick),
            .pulse(event_pulses[i])
         );
      end
   endgenerate

   assign counter_wrap_high_event = event_pulses[0];
   assign counter_wrap_low_event = event_pulses[1];
   assign compare_capture_event = event_pulses[2];

   // ------------------------------------------------------------
   // APB read path
   // ------------------------------------------------------------
   // Read data and error are captured in the setup cycle, so every access takes no wait state.
   reg [31:0] read_data;
   reg read_error;
   reg [31:0] next_read;
   reg next_error;

   always @* begin
      next_read = 32'h00000000;
      next_error = 1'b0;
      case (offset)
         `OFS_COUNTER_CONTROL: next_read = counter_control;
         `OFS_IRQ_REQUEST: next_read[1:0] = irq_request;
         `OFS_IRQ_FORCE: next_read[1:0] = irq_request;
         `OFS_IRQ_ENABLE_MASK: next_read[1:0] = irq_enable_mask;
         `OFS_IRQ_MASKED_VIEW: next_read[1:0] = irq_masked_view;
         `OFS_OUTPUT_ACTION: next_read[5:0] = output_action_control;
         `OFS_COUNT_VALUE: next_read[WIDTH-1:0] = count_value;
         `OFS_TOP_VALUE: next_read[WIDTH-1:0] = top_value;
         `OFS_COMPARE: next_read[WIDTH-1:0] = compare;
         `OFS_COMPARE_SHADOW: next_read[WIDTH-1:0] = compare_shadow;
         `OFS_CAPTURE: next_read[WIDTH-1:0] = capture_value;
         `OFS_RUN_CONTROL: next_read[0] = running;
         default: next_error = 1'b1;
      endcase
      if (paddr[31:6] != 26'h0000000)
         next_error = 1'b1;
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         read_data <= 32'h00000000;
         read_error <= 1'b0;
      end else if (setup) begin
         read_data <= (pwrite || next_error) ? 32'h00000000 : next_read;
         read_error <= next_error;
      end
   end

   assign pready = psel && penable;
   assign prdata = read_data;
   assign pslverr = psel && penable && read_error;
endmodule
`default_nettype wire

// [dv/counter_event_props.sv]
// Assertions on the ports of one counter channel.
// Assumes SYS_DIV of 1, so that a trigger pulse lasts two clocks.
`timescale 1ns/100ps
`default_nettype none
module counter_event_props #(
   parameter SYS_DIV = 1
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic counter_wrap_high_event,
   input wire logic counter_wrap_low_event,
   input wire logic compare_capture_event,
   input wire logic counter_irq,
   input wire logic wave_out,
   input wire logic wave_out_n,
   input wire logic mode_timer,
   input wire logic mode_capture,
   input wire logic mode_quadrature,
   input wire logic mode_pwm,
   input wire logic deadtime_wave_mode,
   input wire logic random_wave_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   wire logic acc = psel && penable;
   wire logic [5:0] modes = {random_wave_mode, deadtime_wave_mode, mode_pwm, mode_quadrature, mode_capture, mode_timer};
   // Codes 001 and 111 select no mode.
   function automatic logic [5:0] dec(input logic [2:0] m);
      dec = (m == 3'h0) ? 6'h01 : (m == 3'h1 || m == 3'h7) ? 6'h00 : 6'h01 << (m - 3'h1);
   endfunction
   chk_mode_decode: assert property (acc && pwrite && paddr == 32'h0 |->
      ##2 modes == dec($past(pwdata[26:24], 2))) else $error("mode outputs wrong");
   chk_wave_pair: assert property (wave_out_n == !wave_out)
      else $error("wave pair not complementary");
   chk_high_width: assert property ($rose(counter_wrap_high_event) |=>
      counter_wrap_high_event ##1 !counter_wrap_high_event) else $error("wrap-high width");
   chk_low_width: assert property ($rose(counter_wrap_low_event) |=>
      counter_wrap_low_event ##1 !counter_wrap_low_event) else $error("wrap-low width");
   chk_compare_width: assert property ($rose(compare_capture_event) |=>
      compare_capture_event ##1 !compare_capture_event) else $error("compare width");
   chk_wave_cause: assert property ($changed(wave_out) |=>
      counter_wrap_high_event || counter_wrap_low_event || compare_capture_event) else $error("wave moved alone");
   chk_irq_view: assert property (acc && !pwrite && paddr == 32'h10 |->
      $past(counter_irq) == (prdata[1:0] != 2'h0)) else $error("irq differs from masked view");
   chk_ready_error: assert property (acc |-> pready && pslverr == (paddr > 32'h2C || paddr[1:0] != 2'h0))
      else $error("ready or error wrong");
   chk_unmapped_err: assert property (acc && !pwrite && paddr > 32'h2C |-> pslverr && prdata == 32'h0)
      else $error("unmapped read accepted");
   cover property ($rose(counter_wrap_low_event));
   cover property ($rose(counter_irq));
   cover property ($rose(mode_capture));
endmodule
bind counter_event_output_logic counter_event_props #(.SYS_DIV(SYS_DIV)) i_props (
   .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .counter_wrap_high_event, .counter_wrap_low_event, .compare_capture_event, .counter_irq, .wave_out,
   .wave_out_n, .mode_timer, .mode_capture, .mode_quadrature, .mode_pwm, .deadtime_wave_mode,
   .random_wave_mode
);
`default_nettype wire

// [dv/trigger_partner.sv]
// Far-side model: the pins and trigger fabric around one counter channel.
// Assumes the channel clock; drives count and capture pins and counts trigger pulses.
`timescale 1ns/100ps
`default_nettype none
module trigger_partner (
   input wire logic clock,
   input wire logic count_enable,
   input wire logic capture_req,
   input wire logic counter_wrap_high_event,
   input wire logic counter_wrap_low_event,
   input wire logic compare_capture_event,
   output var logic count_in,
   output var logic capture_in,
   output var int wh_seen,
   output var int wl_seen,
   output var int cc_seen
);
   logic [2:0] last;
   initial begin
      count_in = 1'b0;
      capture_in = 1'b0;
      last = 3'h0;
      wh_seen = 0;
      wl_seen = 0;
      cc_seen = 0;
   end
   // Each pulse is counted once, at its rising edge.
   always @(posedge clock) begin
      count_in <= count_enable;
      capture_in <= capture_req;
      last <= {counter_wrap_high_event, counter_wrap_low_event, compare_capture_event};
      if (counter_wrap_high_event && !last[2])
         wh_seen <= wh_seen + 1;
      if (counter_wrap_low_event && !last[1])
         wl_seen <= wl_seen + 1;
      if (compare_capture_event && !last[0])
         cc_seen <= cc_seen + 1;
   end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for one counter channel reached over APB.
// Assumes the design at 100 MHz with TICK_DIV and SYS_DIV of 1.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clock = 1'b0;
   logic rstn, psel, penable, pwrite, count_enable, capture_req;
   logic [31:0] paddr, pwdata, q;
   logic e;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, count_in, capture_in, wh_ev, wl_ev, cc_ev, counter_irq, wave_out, wave_out_n;
   wire logic [5:0] modes;
   int wh_seen, wl_seen, cc_seen, gap;
   int err_count = 0;
   int num_checks = 0;
   always #5 clock = ~clock;
   counter_event_output_logic #(.WIDTH(16), .TICK_DIV(1), .SYS_DIV(1)) i_dut (
      .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .count_in, .capture_in,
      .counter_wrap_high_event(wh_ev), .counter_wrap_low_event(wl_ev), .compare_capture_event(cc_ev),
      .counter_irq, .wave_out, .wave_out_n,
      .mode_timer(modes[0]), .mode_capture(modes[1]), .mode_quadrature(modes[2]), .mode_pwm(modes[3]),
      .deadtime_wave_mode(modes[4]), .random_wave_mode(modes[5]));
   trigger_partner i_far (.clock(clock), .count_enable(count_enable), .capture_req(capture_req),
      .counter_wrap_high_event(wh_ev), .counter_wrap_low_event(wl_ev), .compare_capture_event(cc_ev),
      .count_in(count_in), .capture_in(capture_in), .wh_seen(wh_seen), .wl_seen(wl_seen), .cc_seen(cc_seen));
   // ----------
   // Checking and bus tasks
   // ----------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic bad(input string msg);
      $display("BAD %0t %s", $time, msg);
      err_count++;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
         bad($sformatf("got %h want %h", got, exp));
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
         bad($sformatf("got %b want %b", got, exp));
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad("bus hang");
         report_and_stop;
      end
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_word(q, exp);
   endtask
   task automatic chk_irq(input logic exp);
      @(negedge clock);
      chk_bit(counter_irq, exp);
   endtask
   function automatic int seen(input int s);
      return (s == 0) ? wh_seen : (s == 1) ? wl_seen : cc_seen;
   endfunction
   // The bound is far above any period used here.
   task automatic wait_evt(input int s);
      int base;
      base = seen(s);
      gap = 0;
      while (seen(s) == base && gap < 300) begin
         @(posedge clock);
         gap++;
      end
      if (gap >= 300) begin
         bad("no event");
         report_and_stop;
      end
   endtask
   task automatic start(input logic [31:0] ctrl, top, cmp, act);
      apb(1'b1, 32'h2C, 32'h0);
      apb(1'b1, 32'h04, 32'h3);
      apb(1'b1, 32'h00, ctrl);
      apb(1'b1, 32'h1C, top);
      apb(1'b1, 32'h20, cmp);
      apb(1'b1, 32'h14, act);
      apb(1'b1, 32'h2C, 32'h3);
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic dir_case(input logic [1:0] dir, input int top, s, per, input logic hi, lo);
      int w0, l0;
      start({14'h0, dir, 16'h0}, top, 32'hFF, 32'h3F);
      wait_evt(s);
      w0 = wh_seen;
      l0 = wl_seen;
      wait_evt(s);
      wait_evt(s);
      chk_word(gap, per);
      chk_bit(wh_seen > w0, hi);
      chk_bit(wl_seen > l0, lo);
      rd(32'h04, 32'h1);
      $display("direction %0d done", dir);
   endtask
   task automatic act_case;
      logic [1:0] code [5] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h1};
      logic exp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         start(32'h1, 20, 2, {30'hF, code[i]});
         wait_evt(2);
         chk_bit(wave_out, exp[i]);
         chk_bit(wave_out_n, !exp[i]);
      end
      // Compare on leaving top falls on the wrap-high step; compare must win.
      start(32'h0, 4, 4, 32'h34);
      wait_evt(0);
      chk_bit(wave_out, 1'b1);
      $display("actions done");
   endtask
   task automatic irq_case;
      apb(1'b1, 32'h2C, 32'h0);
      rd(32'h04, 32'h3);
      apb(1'b1, 32'h0C, 32'h1);
      rd(32'h10, 32'h1);
      chk_irq(1'b1);
      apb(1'b1, 32'h04, 32'h1);
      rd(32'h08, 32'h2);
      chk_irq(1'b0);
      apb(1'b1, 32'h0C, 32'h2);
      rd(32'h0C, 32'h2);
      chk_irq(1'b1);
      apb(1'b1, 32'h04, 32'h2);
      apb(1'b1, 32'h08, 32'h1);
      rd(32'h04, 32'h1);
      rd(32'h10, 32'h0);
      rd(32'h30, 32'h0);
      chk_bit(e, 1'b1);
      $display("interrupts done");
   endtask
   task automatic mode_case;
      logic [2:0] m [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 32'h0, {5'h0, m[i], 24'h0});
         @(posedge clock);
         @(negedge clock);
         chk_word({26'h0, modes}, 32'h1 << i);
      end
      $display("modes done");
   endtask
   task automatic capture_case;
      count_enable <= 1'b0;
      start(32'h0200_0000, 20, 7, 32'h3F);
      apb(1'b1, 32'h18, 32'h5);
      capture_req <= 1'b1;
      repeat (3) @(posedge clock);
      capture_req <= 1'b0;
      wait_evt(2);
      rd(32'h28, 32'h5);
      rd(32'h20, 32'h5);
      rd(32'h24, 32'h7);
      count_enable <= 1'b1;
      $display("capture done");
   endtask
   initial begin
      {rstn, psel, penable, pwrite, count_enable, capture_req} = 6'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      count_enable <= 1'b1;
      repeat (3) @(posedge clock);
      rd(32'h00, 32'h0);
      rd(32'h04, 32'h0);
      rd(32'h0C, 32'h0);
      rd(32'h14, 32'h3F);
      chk_bit(wave_out_n, 1'b1);
      dir_case(2'h0, 4, 0, 5, 1'b1, 1'b0);
      dir_case(2'h1, 3, 1, 4, 1'b0, 1'b1);
      dir_case(2'h2, 3, 1, 6, 1'b0, 1'b1);
      dir_case(2'h3, 3, 1, 6, 1'b1, 1'b1);
      act_case;
      irq_case;
      mode_case;
      capture_case;
      report_and_stop;
   end
endmodule
`default_nettype wire
